// File: hdl/cie_cfg.svh
`ifndef CIE_CFG_SVH
`define CIE_CFG_SVH
`define CIE_OFS_CTRL 16'h0000
`define CIE_OFS_EOI 16'h0010
`define CIE_OFS_BPR 16'h0008
`define CIE_OFS_ABPR 16'h001c
`define CIE_OFS_APR 16'h00d0
`define CIE_OFS_DIR 16'h1000
`define CIE_BIT_G0EN 0
`define CIE_BIT_G1EN 1
`define CIE_BIT_FIQ 3
`define CIE_BIT_COMMON_BINARY_POINT_SEL 4
`define CIE_BIT_SPLIT_EOI_MODE 9
`define CIE_BIT_SPLIT_EOI_MODE_NS 10
`define CIE_BPR_MAX 3'h7
`define CIE_BPR_RST 3'h2
`define CIE_ABPR_RST 3'h3
`define CIE_ID_SPEC_LO 24'h0003fc
`define CIE_ID_SPEC_HI 24'h0003ff
`define CIE_APR_W 32
`endif

// File: hdl/cie_pkg.sv
package cie_pkg;
  typedef logic [23:0] cie_id_t;
  typedef logic [2:0] cie_bp_t;
  typedef enum logic [1:0] {
    CIE_OP_NONE = 2'b00,
    CIE_OP_DROP = 2'b01,
    CIE_OP_DEACT = 2'b10,
    CIE_OP_BOTH = 2'b11
  } cie_op_t;
endpackage

// File: hdl/cie_cpu_if.sv
// Function
// RL1 - common select 0: binary point for group 0, alias for group 1
// RL2 - common select 1: binary point governs both groups
// RL3 - two states, common set: non-secure read gives secure value plus one, saturated
// RL4 - two states, common set: non-secure binary-point writes are discarded
// RL5 - fast-route bit chooses normal or fast line for group 0
// RL6 - group 1 always signals on the normal line
// RL7 - two states may force fast-route to read one, writes ignored
// RL8 - group 1 enable gates group 1 signalling
// RL9 - group 0 enable gates group 0 signalling
// RL10 - control bits reset to zero, bit 2 reads zero
// RL11 - control register read-write at offset zero, any security
// RL12 - write-only deactivate register at 0x1000 deactivates named interrupt in split mode
// RL13 - identifier occupies bits 23..0, ids 1020..1023 special
// RL14 - without affinity routing bits 23..13 zero, 12..10 source cpu
// RL15 - deactivate acts only when governing mode bit is one
// RL16 - deactivate ignored when governing mode bit is zero
// RL17 - deactivate without drop leaves active-priority bit set
// RL18 - end-of-interrupt at 0x0010 drops priority, deactivates when mode zero
// RL19 - secure writes service group 0; single state both do
// RL20 - processor writes end-of-interrupt for every valid acknowledged id
// RL21 - processor ends nested interrupts in reverse acknowledge order
// RL22 - end-of-interrupt writes with ids 1020..1023 ignored
// RL23 - wrong-group end-of-interrupt writes ignored
// RL24 - mode one: end drops only, deactivate register deactivates; modes reset zero
// RL25 - one active-priority tracking set per security state
`timescale 1ns/100ps
`default_nettype none
`include "cie_cfg.svh"
module cie_cpu_if #(
  parameter bit TWO_STATES = 1'b1,
  parameter bit FIQ_RAO = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_secure,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic ack_valid,
  input wire logic ack_secure,
  input wire logic [4:0] ack_prio_idx,
  input wire logic g0_pend,
  input wire logic g1_pend,
  input wire logic [2:0] pend_prio_grp,
  output logic irq_out,
  output logic fiq_out,
  output cie_pkg::cie_bp_t g0_bp,
  output cie_pkg::cie_bp_t g1_bp,
  output logic drop_valid,
  output logic drop_secure,
  output logic deact_valid,
  output cie_pkg::cie_id_t deact_id,
  output logic apr_reset_valid
);
  import cie_pkg::*;

  function automatic logic is_special(input cie_id_t id);
    is_special = (id >= `CIE_ID_SPEC_LO) && (id <= `CIE_ID_SPEC_HI);
  endfunction

  function automatic logic [`CIE_APR_W-1:0] clr_top(input logic [`CIE_APR_W-1:0] v);
    logic [`CIE_APR_W-1:0] r;
    logic done;
    r = v;
    done = 1'b0;
    for (int i = 0; i < `CIE_APR_W; i++) begin
      if (!done && v[i]) begin
        r[i] = 1'b0;
        done = 1'b1;
      end
    end
    clr_top = r;
  endfunction

  logic g0en_q, g1en_q, fiq_q, common_binary_point_sel_q, eoim_s_q, eoim_ns_q;
  logic [2:0] bpr_q, abpr_q;
  logic [`CIE_APR_W-1:0] apr_s_q, apr_ns_q;
  logic drop_q, drop_sec_q, deact_q, aprr_q;
  cie_id_t deact_id_q;

  wire sel_ctrl = reg_addr == `CIE_OFS_CTRL;
  wire sel_eoi = reg_addr == `CIE_OFS_EOI;
  wire sel_dir = reg_addr == `CIE_OFS_DIR;
  wire sel_bpr = reg_addr == `CIE_OFS_BPR;
  wire sel_abpr = reg_addr == `CIE_OFS_ABPR;
  wire sel_apr = reg_addr == `CIE_OFS_APR;
  wire ns_acc = TWO_STATES && !reg_secure;
  // secure side sees its own mode bit; single state too
  wire fiq_eff = (TWO_STATES && FIQ_RAO) | fiq_q; // RL7
  wire eoim_gov = ns_acc ? eoim_ns_q : eoim_s_q; // RL15
  wire cie_id_t wid = reg_wdata[23:0]; // RL13 RL14
  wire [2:0] bpr_inc = (bpr_q == `CIE_BPR_MAX) ? `CIE_BPR_MAX : bpr_q + 3'h1;
  // group of the eoi: secure or single-state writes service group 0
  wire eoi_g0 = !ns_acc; // RL19
  // no active in the writer's own state while the other state holds one means a wrong-group write (non-secure only with eoim_s_q set)
  wire wrong_grp = eoi_g0 ? (apr_s_q == '0 && apr_ns_q != '0)
                          : (eoim_s_q && apr_ns_q == '0 && apr_s_q != '0); // RL23
  wire ctrl_wr = reg_wr && sel_ctrl; // RL11
  wire eoi_ok = reg_wr && sel_eoi && !is_special(wid) && !wrong_grp; // RL22 RL23
  wire dir_ok = reg_wr && sel_dir && eoim_gov; // RL12 RL15 RL16
  wire eoi_bad = reg_wr && sel_eoi && !is_special(wid) && wrong_grp;
  wire bpr_wr_ok = reg_wr && sel_bpr && !(ns_acc && common_binary_point_sel_q); // RL4

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      g0en_q <= 1'b0; // RL10
      g1en_q <= 1'b0;
      fiq_q <= 1'b0;
      common_binary_point_sel_q <= 1'b0;
      eoim_s_q <= 1'b0; // RL24
      eoim_ns_q <= 1'b0;
      bpr_q <= `CIE_BPR_RST;
      abpr_q <= `CIE_ABPR_RST;
    end else begin
      if (ctrl_wr && ns_acc) begin
        g1en_q <= reg_wdata[0];
        fiq_q <= fiq_q;
        eoim_ns_q <= reg_wdata[`CIE_BIT_SPLIT_EOI_MODE];
      end else if (ctrl_wr) begin
        g0en_q <= reg_wdata[`CIE_BIT_G0EN];
        g1en_q <= reg_wdata[`CIE_BIT_G1EN];
        fiq_q <= reg_wdata[`CIE_BIT_FIQ] & ~FIQ_RAO; // RL7
        common_binary_point_sel_q <= reg_wdata[`CIE_BIT_COMMON_BINARY_POINT_SEL];
        eoim_s_q <= reg_wdata[`CIE_BIT_SPLIT_EOI_MODE];
        eoim_ns_q <= TWO_STATES ? reg_wdata[`CIE_BIT_SPLIT_EOI_MODE_NS] : reg_wdata[`CIE_BIT_SPLIT_EOI_MODE];
      end
      if (bpr_wr_ok && !ns_acc) bpr_q <= reg_wdata[2:0];
      if ((bpr_wr_ok && ns_acc) || (reg_wr && sel_abpr)) abpr_q <= reg_wdata[2:0];
    end
  end

  // active priorities: set by acknowledge, cleared by drop; set wins on the same bit
  logic [`CIE_APR_W-1:0] ack_bit;
  assign ack_bit = `CIE_APR_W'(1) << ack_prio_idx;
  // wrong-group end only flags the error: the writer's own state holds no active to reset
  wire drop_s = eoi_ok && eoi_g0; // RL23
  wire drop_ns = eoi_ok && !eoi_g0;
  wire set_s = ack_valid && (ack_secure || !TWO_STATES);
  wire set_ns = ack_valid && !(ack_secure || !TWO_STATES);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      apr_s_q <= '0; // RL25
      apr_ns_q <= '0;
    end else begin
      apr_s_q <= (drop_s ? clr_top(apr_s_q) : apr_s_q) | (set_s ? ack_bit : '0);
      apr_ns_q <= (drop_ns ? clr_top(apr_ns_q) : apr_ns_q) | (set_ns ? ack_bit : '0);
    end
  end

  // deactivate alone never touches the active priorities
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      drop_q <= 1'b0;
      drop_sec_q <= 1'b0;
      deact_q <= 1'b0;
      deact_id_q <= '0;
      aprr_q <= 1'b0;
    end else begin
      drop_q <= eoi_ok; // RL18
      drop_sec_q <= eoi_g0;
      deact_q <= (eoi_ok && !eoim_gov) || dir_ok; // RL17 RL18 RL24
      deact_id_q <= (eoi_ok || dir_ok) ? wid : deact_id_q;
      aprr_q <= eoi_bad;
    end
  end
  assign drop_valid = drop_q;
  assign drop_secure = drop_sec_q;
  assign deact_valid = deact_q;
  assign deact_id = deact_id_q;
  assign apr_reset_valid = aprr_q;

  // group selection of binary points for preemption
  assign g0_bp = bpr_q; // RL1
  assign g1_bp = common_binary_point_sel_q ? bpr_q : abpr_q; // RL1 RL2

  // pend_prio_grp[0]=group0 pending above running, [1]=group1
  wire g0_sig = g0_pend && pend_prio_grp[0] && g0en_q; // RL9
  wire g1_sig = g1_pend && pend_prio_grp[1] && g1en_q; // RL8
  assign fiq_out = g0_sig && fiq_eff; // RL5
  assign irq_out = (g0_sig && !fiq_eff) || g1_sig; // RL5 RL6

  logic [31:0] ctrl_rd;
  always_comb begin
    ctrl_rd = '0; // RL10
    if (ns_acc) begin
      ctrl_rd[0] = g1en_q;
      ctrl_rd[`CIE_BIT_SPLIT_EOI_MODE] = eoim_ns_q;
    end else begin
      ctrl_rd[`CIE_BIT_G0EN] = g0en_q;
      ctrl_rd[`CIE_BIT_G1EN] = g1en_q;
      ctrl_rd[`CIE_BIT_FIQ] = fiq_eff;
      ctrl_rd[`CIE_BIT_COMMON_BINARY_POINT_SEL] = common_binary_point_sel_q;
      ctrl_rd[`CIE_BIT_SPLIT_EOI_MODE] = eoim_s_q;
      ctrl_rd[`CIE_BIT_SPLIT_EOI_MODE_NS] = TWO_STATES ? eoim_ns_q : 1'b0;
    end
  end

  wire [2:0] bpr_view = ns_acc ? (common_binary_point_sel_q ? bpr_inc : abpr_q) : bpr_q; // RL3
  wire [31:0] rd_mux = sel_ctrl ? ctrl_rd :
                       sel_bpr ? {29'h0, bpr_view} :
                       sel_abpr ? {29'h0, abpr_q} :
                       sel_apr ? (ns_acc ? apr_ns_q : apr_s_q) : 32'h0;

  always_ff @(posedge clk) begin
    if (!rst_b) reg_rdata <= '0;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

  chk_ctrl_reset_zero: assert property (@(posedge clk) // RL10
    $rose(rst_b) |-> !g0en_q && !g1en_q && !common_binary_point_sel_q && !eoim_s_q)
    else $error("control bits not zero after reset");
  chk_g1_never_fiq: assert property (@(posedge clk) disable iff (!rst_b) // RL6
    (g1_sig && !g0_sig) |-> irq_out && !fiq_out)
    else $error("group 1 left the normal line");
  chk_fiq_route: assert property (@(posedge clk) disable iff (!rst_b) // RL5
    g0_sig |-> (fiq_out == fiq_eff))
    else $error("group 0 routed wrong");
  chk_g0_gate: assert property (@(posedge clk) disable iff (!rst_b) // RL9
    (!g0en_q && !g1_sig) |-> !irq_out && !fiq_out)
    else $error("group 0 signalled while disabled");
  chk_special_ignored: assert property (@(posedge clk) disable iff (!rst_b) // RL22
    (reg_wr && sel_eoi && is_special(wid)) |=> !drop_valid && !deact_valid)
    else $error("special id acted on");
  chk_dir_gated: assert property (@(posedge clk) disable iff (!rst_b) // RL16
    (reg_wr && sel_dir && !eoim_gov && !(reg_wr && sel_eoi)) |=> !deact_valid)
    else $error("deactivate taken in combined mode");
  chk_ns_bpr_kept: assert property (@(posedge clk) disable iff (!rst_b) // RL4
    (reg_wr && sel_bpr && ns_acc && common_binary_point_sel_q) |=> $stable(bpr_q))
    else $error("non-secure binary point write took effect");
  chk_eoi_split: assert property (@(posedge clk) disable iff (!rst_b) // RL18
    (eoi_ok && eoim_gov) |=> drop_valid && !deact_valid)
    else $error("split-mode end deactivated");
  chk_g1_bp_sel: assert property (@(posedge clk) disable iff (!rst_b) // RL2
    common_binary_point_sel_q |-> g1_bp == bpr_q)
    else $error("group 1 binary point not common");
  chk_bpr_write_lands: assert property (@(posedge clk) disable iff (!rst_b) // RL1
    (reg_wr && sel_bpr && !ns_acc) |=> bpr_q == $past(reg_wdata[2:0]))
    else $error("secure binary point write lost");
  chk_ns_bpr_alias: assert property (@(posedge clk) disable iff (!rst_b) // RL1
    (reg_wr && sel_bpr && ns_acc && !common_binary_point_sel_q) |=> abpr_q == $past(reg_wdata[2:0]))
    else $error("non-secure binary point write missed the alias");
  chk_ns_bpr_view: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    (reg_rd && sel_bpr && ns_acc && common_binary_point_sel_q) |=>
      reg_rdata[2:0] == (&$past(bpr_q) ? `CIE_BPR_MAX : $past(bpr_q) + 3'h1))
    else $error("non-secure binary point view not incremented");
  chk_bpr_high_zero: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    (reg_rd && sel_bpr) |=> reg_rdata[31:3] == 29'h0)
    else $error("binary point read upper bits not zero");
  chk_ns_ctrl_kept: assert property (@(posedge clk) disable iff (!rst_b) // RL11
    (ctrl_wr && ns_acc) |=> $stable(fiq_q) && $stable(g0en_q) && $stable(common_binary_point_sel_q))
    else $error("non-secure control write touched secure bits");
  chk_g1_gate: assert property (@(posedge clk) disable iff (!rst_b) // RL8
    (!g1en_q && !g0_sig) |-> !irq_out && !fiq_out)
    else $error("group 1 signalled while disabled");
  chk_g1_on_irq: assert property (@(posedge clk) disable iff (!rst_b) // RL6
    g1_sig |-> irq_out)
    else $error("group 1 not on the normal line");
  chk_fiq_g0_only: assert property (@(posedge clk) disable iff (!rst_b) // RL5
    fiq_out |-> g0_sig)
    else $error("fast line raised without group 0");
  chk_ctrl_rd_rsvd: assert property (@(posedge clk) disable iff (!rst_b) // RL10
    (reg_rd && sel_ctrl) |=> reg_rdata[2] == 1'b0 && reg_rdata[31:11] == 21'h0)
    else $error("control read reserved bits not zero");
  chk_ctrl_wr_lands: assert property (@(posedge clk) disable iff (!rst_b) // RL11
    (ctrl_wr && !ns_acc) |=> g0en_q == $past(reg_wdata[`CIE_BIT_G0EN]) &&
      common_binary_point_sel_q == $past(reg_wdata[`CIE_BIT_COMMON_BINARY_POINT_SEL]))
    else $error("secure control write lost");
  chk_ctrl_readback: assert property (@(posedge clk) disable iff (!rst_b) // RL11
    (reg_rd && sel_ctrl && !ns_acc) |=> reg_rdata[`CIE_BIT_G1EN] == $past(g1en_q))
    else $error("control read back wrong");
  chk_dir_acts: assert property (@(posedge clk) disable iff (!rst_b) // RL12
    (reg_wr && sel_dir && eoim_gov) |=> deact_valid && deact_id == $past(wid))
    else $error("deactivate write not carried out");
  chk_eoi_id: assert property (@(posedge clk) disable iff (!rst_b) // RL13
    eoi_ok |=> deact_id == $past(wid))
    else $error("end identifier not carried");
  chk_sgi_src_kept: assert property (@(posedge clk) disable iff (!rst_b) // RL14
    (reg_wr && sel_dir && eoim_gov) |=> deact_id[12:10] == $past(reg_wdata[12:10]))
    else $error("source cpu field lost");
  chk_dir_apr_kept: assert property (@(posedge clk) disable iff (!rst_b) // RL17
    (reg_wr && sel_dir && !ack_valid) |=> $stable(apr_s_q) && $stable(apr_ns_q))
    else $error("deactivate changed active priorities");
  chk_eoi_combined: assert property (@(posedge clk) disable iff (!rst_b) // RL18
    (eoi_ok && !eoim_gov) |=> drop_valid && deact_valid)
    else $error("combined-mode end did not deactivate");
  chk_eoi_group: assert property (@(posedge clk) disable iff (!rst_b) // RL19
    eoi_ok |=> drop_secure == (!TWO_STATES || $past(reg_secure)))
    else $error("end serviced the wrong group");
  chk_wrong_grp_kept: assert property (@(posedge clk) disable iff (!rst_b) // RL23
    eoi_bad |=> !drop_valid && !deact_valid && apr_reset_valid)
    else $error("wrong-group end acted on");
  chk_wrong_grp_apr: assert property (@(posedge clk) disable iff (!rst_b) // RL23
    (eoi_bad && !ack_valid) |=> $stable(apr_s_q) && $stable(apr_ns_q))
    else $error("wrong-group end changed active priorities");
  chk_apr_drop: assert property (@(posedge clk) disable iff (!rst_b) // RL25
    (drop_s && !set_s) |=>
      apr_s_q == ($past(apr_s_q) & ($past(apr_s_q) - `CIE_APR_W'(1))))
    else $error("drop did not clear the highest active");
  chk_ack_sets: assert property (@(posedge clk) disable iff (!rst_b) // RL25
    set_s |=> apr_s_q[$past(ack_prio_idx)])
    else $error("acknowledge did not mark active");
  chk_special_no_apr: assert property (@(posedge clk) disable iff (!rst_b) // RL22
    (reg_wr && sel_eoi && is_special(wid) && !ack_valid) |=>
      $stable(apr_s_q) && $stable(apr_ns_q))
    else $error("special id changed active priorities");
  chk_mode_reset: assert property (@(posedge clk) // RL24
    $rose(rst_b) |-> !eoim_ns_q && !fiq_q && apr_s_q == '0 && apr_ns_q == '0)
    else $error("mode or active bits not zero after reset");
  chk_rdata_hold: assert property (@(posedge clk) disable iff (!rst_b) // RL11
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule
`default_nettype wire

// File: dv/cie_pe_model.sv
`timescale 1ns/100ps
`default_nettype none
module cie_pe_model (
  input wire logic clk,
  input wire logic irq_out,
  input wire logic fiq_out,
  output logic ack_valid,
  output logic ack_secure,
  output logic [4:0] ack_prio_idx,
  output logic g0_pend,
  output logic g1_pend,
  output logic [2:0] pend_prio_grp
);
  initial begin
    ack_valid = 1'b0;
    ack_secure = 1'b0;
    ack_prio_idx = 5'h00;
    g0_pend = 1'b0;
    g1_pend = 1'b0;
    pend_prio_grp = 3'h0;
  end
  task automatic pend(input logic p0, input logic p1);
    @(negedge clk);
    g0_pend = p0;
    g1_pend = p1;
    pend_prio_grp = {1'b0, p1, p0};
  endtask
  // acknowledge only what is signalled, as a real processor would
  task automatic ack(input logic sec, input logic [4:0] idx);
    @(negedge clk);
    if (irq_out || fiq_out) begin
      ack_valid = 1'b1;
      ack_secure = sec;
      ack_prio_idx = idx;
      @(negedge clk);
      ack_valid = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: dv/cpu_irq_interface_eoi_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_irq_interface_eoi_ctrl_tb;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_secure = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v;
  logic ack_valid, ack_secure, g0_pend, g1_pend, irq_out, fiq_out;
  logic drop_valid, drop_secure, deact_valid, apr_reset_valid;
  logic [4:0] ack_prio_idx;
  logic [2:0] pend_prio_grp, pv;
  cie_pkg::cie_bp_t g0_bp, g1_bp;
  cie_pkg::cie_id_t deact_id, pid;
  int errors = 0, compares = 0;
  initial forever #2 clk = ~clk;
  cie_cpu_if i_cie_cpu_if (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_secure(reg_secure), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .ack_valid(ack_valid), .ack_secure(ack_secure),
    .ack_prio_idx(ack_prio_idx), .g0_pend(g0_pend), .g1_pend(g1_pend),
    .pend_prio_grp(pend_prio_grp), .irq_out(irq_out), .fiq_out(fiq_out), .g0_bp(g0_bp),
    .g1_bp(g1_bp), .drop_valid(drop_valid), .drop_secure(drop_secure),
    .deact_valid(deact_valid), .deact_id(deact_id), .apr_reset_valid(apr_reset_valid));
  cie_pe_model i_pe (.clk(clk), .irq_out(irq_out), .fiq_out(fiq_out),
    .ack_valid(ack_valid), .ack_secure(ack_secure), .ack_prio_idx(ack_prio_idx),
    .g0_pend(g0_pend), .g1_pend(g1_pend), .pend_prio_grp(pend_prio_grp));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // pulses and read data are caught on the falling edge after the access edge
  task automatic wr(input logic s, input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_secure = s;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    pv = {apr_reset_valid, drop_valid, deact_valid};
    pid = deact_id;
  endtask
  task automatic rd(input logic s, input logic [15:0] a);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_secure = s;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    rd_v = reg_rdata;
  endtask
  task automatic summarize;
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    rd(1'b1, 16'h0000);
    chk(rd_v, 32'h0);
    chk({g0_bp, g1_bp}, {3'h2, 3'h3});
    wr(1'b0, 16'h0008, 32'h00000001);
    chk({g0_bp, g1_bp}, {3'h2, 3'h1});
    wr(1'b1, 16'h0000, 32'h0000000f);
    rd(1'b0, 16'h0000);
    chk(rd_v, 32'h00000001);
    rd(1'b1, 16'h0000);
    chk(rd_v, 32'h0000000b);
    i_pe.pend(1'b1, 1'b0);
    #1 chk({fiq_out, irq_out}, 2'b10);
    i_pe.pend(1'b0, 1'b1);
    #1 chk({fiq_out, irq_out}, 2'b01);
    wr(1'b1, 16'h0000, 32'h00000009);
    chk({fiq_out, irq_out}, 2'b00);
    i_pe.pend(1'b1, 1'b0);
    wr(1'b1, 16'h0000, 32'h00000008);
    chk({fiq_out, irq_out}, 2'b00);
    wr(1'b1, 16'h0000, 32'h00000003);
    chk({fiq_out, irq_out}, 2'b01);
    i_pe.ack(1'b1, 5'h05);
    i_pe.ack(1'b1, 5'h03);
    for (int i = 0; i < 4; i++) begin
      wr(1'b1, 16'h0010, 32'h000003fc + i);
      chk(pv, 3'b000);
    end
    // nested ends come back in reverse order, wide junk in the top byte
    wr(1'b1, 16'h0010, 32'hff000c05);
    chk({pv, pid}, {3'b011, 24'h000c05});
    wr(1'b1, 16'h0010, 32'h00000020);
    chk({pv, pid}, {3'b011, 24'h000020});
    wr(1'b1, 16'h0000, 32'h00000203);
    i_pe.ack(1'b1, 5'h04);
    wr(1'b1, 16'h0010, 32'h00000021);
    chk(pv, 3'b010);
    wr(1'b1, 16'h1000, 32'h00000021);
    chk({pv, pid}, {3'b001, 24'h000021});
    i_pe.ack(1'b1, 5'h06);
    wr(1'b1, 16'h1000, 32'h00000022);
    chk(pv, 3'b001);
    rd(1'b1, 16'h00d0);
    chk(rd_v & 32'h00000040, 32'h00000040);
    wr(1'b0, 16'h1000, 32'h00000023);
    chk(pv, 3'b000);
    wr(1'b1, 16'h0010, 32'h00000022);
    i_pe.ack(1'b0, 5'h07);
    wr(1'b1, 16'h0010, 32'h00000024);
    chk(pv, 3'b100);
    rd(1'b0, 16'h00d0);
    chk(rd_v, 32'h00000080);
    wr(1'b0, 16'h0010, 32'h00000027);
    chk({pv, drop_secure}, {3'b011, 1'b0});
    wr(1'b0, 16'h0000, 32'h00000201);
    rd(1'b1, 16'h0000);
    chk(rd_v, 32'h00000603);
    wr(1'b1, 16'h0008, 32'h00000004);
    wr(1'b1, 16'h0000, 32'h00000213);
    chk({g0_bp, g1_bp}, {3'h4, 3'h4});
    rd(1'b0, 16'h0008);
    chk(rd_v, 32'h00000005);
    wr(1'b0, 16'h0008, 32'h00000001);
    rd(1'b1, 16'h0008);
    chk(rd_v, 32'h00000004);
    wr(1'b1, 16'h0008, 32'h00000007);
    rd(1'b0, 16'h0008);
    chk(rd_v, 32'h00000007);
    summarize;
  end
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    summarize;
  end
endmodule
`default_nettype wire
